// file: hw/otfm_regs.svh
`ifndef OTFM_REGS_SVH
`define OTFM_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OTFM_OFS_A_FUNC 4'h0
`define OTFM_OFS_B_FUNC 4'h1
`define OTFM_OFS_RY_FUNC 4'h2
`define OTFM_OFS_AM_SEL 4'h3
`define OTFM_OFS_A_POL 4'h4
`define OTFM_OFS_B_POL 4'h5
`define OTFM_OFS_RY_POL 4'h6
`define OTFM_OFS_WD_LO 4'h7
`define OTFM_OFS_WD_HI 4'h8
`define OTFM_OFS_BOOL_OP 4'h9
`define OTFM_OFS_STATUS 4'ha

// ----------------------------------------
// Reset values
// ----------------------------------------
`define OTFM_RST_A_FUNC 8'h01
`define OTFM_RST_B_FUNC 8'h00
`define OTFM_RST_RY_FUNC 8'h05
`define OTFM_RST_AM_SEL 8'h00
`define OTFM_RST_A_POL 8'h00
`define OTFM_RST_B_POL 8'h00
`define OTFM_RST_RY_POL 8'h01
`define OTFM_RST_WD 16'h0000
`define OTFM_RST_BOOL_OP 8'h00

// ----------------------------------------
// Encodings
// ----------------------------------------
`define OTFM_POL_NO 8'h00
`define OTFM_POL_NC 8'h01
`define OTFM_FN_RUN 8'h00
`define OTFM_FN_AT_SPEED 8'h01
`define OTFM_FN_OVER_SPEED 8'h02
`define OTFM_FN_OVERLOAD 8'h03
`define OTFM_FN_PID_DEV 8'h04
`define OTFM_FN_ALARM 8'h05
`define OTFM_FN_LOSS 8'h06
`define OTFM_FN_SECOND 8'h07
`define OTFM_FN_NET 8'h08
`define OTFM_FN_LOGIC 8'h09
`define OTFM_AM_FREQ 8'h00
`define OTFM_AM_CURRENT 8'h01
`define OTFM_BOOL_AND 8'h00
`define OTFM_BOOL_OR 8'h01
`define OTFM_BOOL_XOR 8'h02

// ----------------------------------------
// Analog loss and timing
// ----------------------------------------
// Current input in 0.01 mA units; 4 mA
`define OTFM_LOSS_CURRENT 16'h0190
`define OTFM_CLK_MHZ 200
`define OTFM_WD_TICK_MS 10
`define OTFM_WD_TICK_CYC (`OTFM_WD_TICK_MS * 1000 * `OTFM_CLK_MHZ)

`endif

// file: hw/otfm_pkg.sv
package otfm_pkg;

	// ----------------------------------------
	// Drive status bundle
	// ----------------------------------------
	typedef struct packed {
		logic run_mode;
		logic output_on;
		logic ramping;
		logic [15:0] freq_out;
		logic [15:0] freq_set;
		logic [15:0] current;
		logic [15:0] overload_level;
		logic [15:0] pid_error;
		logic [15:0] pid_dev_level;
		logic alarm_event;
		logic alarm_clear;
		logic [15:0] voltage_analog_input;
		logic [15:0] voltage_loss_threshold;
		logic [15:0] current_analog_input;
		logic [15:0] process_value;
		logic [15:0] feedback_high_limit;
		logic [15:0] feedback_low_limit;
		logic comm_activity;
		logic bool_in_a;
		logic bool_in_b;
		logic [15:0] speed_pu;
		logic [15:0] current_pu;
	} otfm_drive_t;

	// ----------------------------------------
	// Block state
	// ----------------------------------------
	typedef struct packed {
		logic [2:0][7:0] func_sel;
		logic [2:0][7:0] polarity;
		logic [7:0] analog_monitor_select;
		logic [15:0] comm_watchdog_period;
		logic [7:0] boolean_operator_select;
		logic alarm_flag;
		logic second_stage_flag;
		logic run_prev;
		logic [31:0] tick_cnt;
		logic [15:0] wd_ticks;
		logic [2:0] out_on;
		logic [15:0] analog_monitor_out;
		logic [7:0] rdata;
	} otfm_state_t;

endpackage

// file: hw/otfm_mux.sv
`timescale 1ns/10ps
`include "otfm_regs.svh"
module otfm_mux #(
	parameter int unsigned WD_TICK_CYCLES = `OTFM_WD_TICK_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Drive status
	input otfm_pkg::otfm_drive_t drive,
	// Outputs: high means transistor or relay coil on
	output logic logic_out_a_sink,
	output logic logic_out_b_sink,
	output logic alarm_relay_energize,
	output logic [15:0] analog_monitor_out
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	otfm_pkg::otfm_state_t s_q;
	otfm_pkg::otfm_state_t s_d;
	logic [2:0] cond;
	logic at_speed_flag;
	logic over_speed_flag;
	logic overload_warning;
	logic pid_deviation_flag;
	logic analog_loss_flag;
	logic network_timeout_flag;
	logic bool_result;

	// ----------------------------------------
	// Status conditions
	// ----------------------------------------
	assign at_speed_flag = drive.output_on && !drive.ramping &&
		(drive.freq_out == drive.freq_set);
	assign over_speed_flag = drive.output_on && (drive.freq_out >= drive.freq_set);
	assign overload_warning = drive.current > drive.overload_level;
	assign pid_deviation_flag = drive.pid_error > drive.pid_dev_level;
	assign analog_loss_flag = (drive.voltage_analog_input < drive.voltage_loss_threshold) ||
		(drive.current_analog_input < `OTFM_LOSS_CURRENT);
	assign network_timeout_flag = (s_q.comm_watchdog_period != 16'h0000) &&
		(s_q.wd_ticks >= s_q.comm_watchdog_period);

	always_comb begin
		case (s_q.boolean_operator_select)
			`OTFM_BOOL_AND: bool_result = drive.bool_in_a & drive.bool_in_b;
			`OTFM_BOOL_OR: bool_result = drive.bool_in_a | drive.bool_in_b;
			`OTFM_BOOL_XOR: bool_result = drive.bool_in_a ^ drive.bool_in_b;
			default: bool_result = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Per output function selection
	// ----------------------------------------
	for (genvar i = 0; i < 3; i++) begin : g_sel
		always_comb begin
			case (s_q.func_sel[i])
				`OTFM_FN_RUN: cond[i] = drive.run_mode;
				`OTFM_FN_AT_SPEED: cond[i] = at_speed_flag;
				`OTFM_FN_OVER_SPEED: cond[i] = over_speed_flag;
				`OTFM_FN_OVERLOAD: cond[i] = overload_warning;
				`OTFM_FN_PID_DEV: cond[i] = pid_deviation_flag;
				`OTFM_FN_ALARM: cond[i] = s_q.alarm_flag;
				`OTFM_FN_LOSS: cond[i] = analog_loss_flag;
				`OTFM_FN_SECOND: cond[i] = s_q.second_stage_flag;
				`OTFM_FN_NET: cond[i] = network_timeout_flag;
				`OTFM_FN_LOGIC: cond[i] = bool_result;
				default: cond[i] = 1'b0;
			endcase
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.run_prev = drive.run_mode;
		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				`OTFM_OFS_A_FUNC: s_d.func_sel[0] = reg_wdata;
				`OTFM_OFS_B_FUNC: s_d.func_sel[1] = reg_wdata;
				`OTFM_OFS_RY_FUNC: s_d.func_sel[2] = reg_wdata;
				`OTFM_OFS_AM_SEL: s_d.analog_monitor_select = reg_wdata;
				`OTFM_OFS_A_POL: s_d.polarity[0] = reg_wdata;
				`OTFM_OFS_B_POL: s_d.polarity[1] = reg_wdata;
				`OTFM_OFS_RY_POL: s_d.polarity[2] = reg_wdata;
				`OTFM_OFS_WD_LO: s_d.comm_watchdog_period[7:0] = reg_wdata;
				`OTFM_OFS_WD_HI: s_d.comm_watchdog_period[15:8] = reg_wdata;
				`OTFM_OFS_BOOL_OP: s_d.boolean_operator_select = reg_wdata;
				default: s_d.rdata = s_q.rdata;
			endcase
		end
		// Register reads, data in the next cycle only
		s_d.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`OTFM_OFS_A_FUNC: s_d.rdata = s_q.func_sel[0];
				`OTFM_OFS_B_FUNC: s_d.rdata = s_q.func_sel[1];
				`OTFM_OFS_RY_FUNC: s_d.rdata = s_q.func_sel[2];
				`OTFM_OFS_AM_SEL: s_d.rdata = s_q.analog_monitor_select;
				`OTFM_OFS_A_POL: s_d.rdata = s_q.polarity[0];
				`OTFM_OFS_B_POL: s_d.rdata = s_q.polarity[1];
				`OTFM_OFS_RY_POL: s_d.rdata = s_q.polarity[2];
				`OTFM_OFS_WD_LO: s_d.rdata = s_q.comm_watchdog_period[7:0];
				`OTFM_OFS_WD_HI: s_d.rdata = s_q.comm_watchdog_period[15:8];
				`OTFM_OFS_BOOL_OP: s_d.rdata = s_q.boolean_operator_select;
				`OTFM_OFS_STATUS: s_d.rdata = {2'b00, network_timeout_flag,
					s_q.second_stage_flag, s_q.alarm_flag, s_q.out_on};
				default: s_d.rdata = 8'h00;
			endcase
		end
		// Alarm latch, a new alarm wins over a clear
		if (drive.alarm_event) begin
			s_d.alarm_flag = 1'b1;
		end else if (drive.alarm_clear) begin
			s_d.alarm_flag = 1'b0;
		end
		// Second stage latch
		if (drive.run_mode && (drive.process_value < drive.feedback_low_limit)) begin
			s_d.second_stage_flag = 1'b1;
		end else if ((drive.process_value > drive.feedback_high_limit) ||
			(s_q.run_prev && !drive.run_mode)) begin
			s_d.second_stage_flag = 1'b0;
		end
		// Communications watchdog in 10 ms ticks
		if (drive.comm_activity) begin
			s_d.tick_cnt = 32'h0000_0000;
			s_d.wd_ticks = 16'h0000;
		end else if (s_q.tick_cnt >= 32'(WD_TICK_CYCLES - 1)) begin
			s_d.tick_cnt = 32'h0000_0000;
			if (s_q.wd_ticks != 16'hffff) begin
				s_d.wd_ticks = s_q.wd_ticks + 16'h0001;
			end
		end else begin
			s_d.tick_cnt = s_q.tick_cnt + 32'h0000_0001;
		end
		// Polarity after selection
		for (int k = 0; k < 3; k++) begin
			s_d.out_on[k] = cond[k] ^ (s_q.polarity[k] == `OTFM_POL_NC);
		end
		// Analog monitor
		case (s_q.analog_monitor_select)
			`OTFM_AM_FREQ: s_d.analog_monitor_out = drive.speed_pu;
			`OTFM_AM_CURRENT: s_d.analog_monitor_out = drive.current_pu;
			default: s_d.analog_monitor_out = 16'h0000;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.func_sel[0] <= `OTFM_RST_A_FUNC;
			s_q.func_sel[1] <= `OTFM_RST_B_FUNC;
			s_q.func_sel[2] <= `OTFM_RST_RY_FUNC;
			s_q.analog_monitor_select <= `OTFM_RST_AM_SEL;
			s_q.polarity[0] <= `OTFM_RST_A_POL;
			s_q.polarity[1] <= `OTFM_RST_B_POL;
			s_q.polarity[2] <= `OTFM_RST_RY_POL;
			s_q.comm_watchdog_period <= `OTFM_RST_WD;
			s_q.boolean_operator_select <= `OTFM_RST_BOOL_OP;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign logic_out_a_sink = s_q.out_on[0];
	assign logic_out_b_sink = s_q.out_on[1];
	assign alarm_relay_energize = s_q.out_on[2];
	assign analog_monitor_out = s_q.analog_monitor_out;
	assign reg_rdata = s_q.rdata;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	pol_apply_a: assert property (@(posedge core_clk) disable iff (rst)
		!$past(rst) |->
		s_q.out_on[0] == ($past(cond[0]) ^ ($past(s_q.polarity[0]) == `OTFM_POL_NC)))
		else $error("logic out a not condition xor polarity");

	no_invert_a: assert property (@(posedge core_clk) disable iff (rst)
		(!rst && s_q.polarity[0] == `OTFM_POL_NO && cond[0]) |=> logic_out_a_sink)
		else $error("normally open output not sinking when true");

	nc_invert_a: assert property (@(posedge core_clk) disable iff (rst)
		(!rst && s_q.polarity[1] == `OTFM_POL_NC && cond[1]) |=> !logic_out_b_sink)
		else $error("normally closed output sinking when true");

	relay_invert_a: assert property (@(posedge core_clk) disable iff (rst)
		(!rst && s_q.polarity[2] == `OTFM_POL_NC && $stable(cond[2])) |=>
		(alarm_relay_energize != $past(cond[2])))
		else $error("relay sense not inverted");

	run_select_a: assert property (@(posedge core_clk) disable iff (rst)
		(!rst && s_q.func_sel[1] == `OTFM_FN_RUN && s_q.polarity[1] == `OTFM_POL_NO)
		|=> logic_out_b_sink == $past(drive.run_mode))
		else $error("run function not following run mode");

	arrive_ramp_a: assert property (@(posedge core_clk) disable iff (rst)
		(drive.ramping || !drive.output_on) |-> !at_speed_flag)
		else $error("arrival active while ramping or off");

	over_freq_a: assert property (@(posedge core_clk) disable iff (rst)
		(drive.output_on && drive.freq_out >= drive.freq_set) |-> over_speed_flag)
		else $error("over frequency flag missing");

	alarm_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		(!rst && drive.alarm_event) |=> s_q.alarm_flag)
		else $error("alarm not latched");

	alarm_keep_a: assert property (@(posedge core_clk) disable iff (rst)
		(s_q.alarm_flag && !drive.alarm_clear) |=> s_q.alarm_flag)
		else $error("alarm dropped without clear");

	loss_current_a: assert property (@(posedge core_clk) disable iff (rst)
		(drive.current_analog_input < `OTFM_LOSS_CURRENT) |-> analog_loss_flag)
		else $error("current loop loss not flagged");

	stage_stop_a: assert property (@(posedge core_clk) disable iff (rst)
		($fell(drive.run_mode)) |=> !s_q.second_stage_flag)
		else $error("second stage not off on stop");

	stage_on_a: assert property (@(posedge core_clk) disable iff (rst)
		(!rst && drive.run_mode && drive.process_value < drive.feedback_low_limit)
		|=> s_q.second_stage_flag)
		else $error("second stage not on below low limit");

	wd_clear_a: assert property (@(posedge core_clk) disable iff (rst)
		drive.comm_activity |=> !network_timeout_flag)
		else $error("network flag set right after activity");

	bad_code_a: assert property (@(posedge core_clk) disable iff (rst)
		(s_q.func_sel[0] > `OTFM_FN_LOGIC) |-> !cond[0])
		else $error("unsupported code gave active condition");

	monitor_cur_a: assert property (@(posedge core_clk) disable iff (rst)
		(!rst && s_q.analog_monitor_select == `OTFM_AM_CURRENT) |=>
		analog_monitor_out == $past(drive.current_pu))
		else $error("monitor not showing current");

	read_late_a: assert property (@(posedge core_clk) disable iff (rst)
		(!rst && reg_rd && reg_addr == `OTFM_OFS_RY_POL) |=>
		reg_rdata == $past(s_q.polarity[2]))
		else $error("relay polarity read back wrong");

	arrive_on_a: assert property (@(posedge core_clk) disable iff (rst)
		(!rst && s_q.func_sel[0] == `OTFM_FN_AT_SPEED && s_q.polarity[0] == `OTFM_POL_NO &&
		drive.output_on && !drive.ramping && drive.freq_out == drive.freq_set)
		|=> logic_out_a_sink)
		else $error("arrival not shown at set frequency");

	below_freq_a: assert property (@(posedge core_clk) disable iff (rst)
		(!drive.output_on || drive.freq_out < drive.freq_set) |-> !over_speed_flag)
		else $error("over frequency flag while off or below");

	overload_out_a: assert property (@(posedge core_clk) disable iff (rst)
		(!rst && s_q.func_sel[1] == `OTFM_FN_OVERLOAD && s_q.polarity[1] == `OTFM_POL_NO &&
		drive.current > drive.overload_level) |=> logic_out_b_sink)
		else $error("overload warning not shown");

	deviation_out_a: assert property (@(posedge core_clk) disable iff (rst)
		(!rst && s_q.func_sel[0] == `OTFM_FN_PID_DEV && s_q.polarity[0] == `OTFM_POL_NO &&
		drive.pid_error <= drive.pid_dev_level) |=> !logic_out_a_sink)
		else $error("deviation shown within threshold");

	loss_volt_a: assert property (@(posedge core_clk) disable iff (rst)
		(drive.voltage_analog_input < drive.voltage_loss_threshold) |-> analog_loss_flag)
		else $error("voltage input loss not flagged");

	loss_none_a: assert property (@(posedge core_clk) disable iff (rst)
		(drive.voltage_analog_input >= drive.voltage_loss_threshold &&
		drive.current_analog_input >= `OTFM_LOSS_CURRENT) |-> !analog_loss_flag)
		else $error("loss flagged without signal loss");

	wd_off_a: assert property (@(posedge core_clk) disable iff (rst)
		(s_q.comm_watchdog_period == 16'h0000) |-> !network_timeout_flag)
		else $error("network flag with watchdog disabled");

	tick_bound_a: assert property (@(posedge core_clk) disable iff (rst)
		s_q.tick_cnt < 32'(WD_TICK_CYCLES))
		else $error("watchdog tick counter out of range");

	bool_xor_a: assert property (@(posedge core_clk) disable iff (rst)
		(!rst && s_q.func_sel[0] == `OTFM_FN_LOGIC && s_q.polarity[0] == `OTFM_POL_NO &&
		s_q.boolean_operator_select == `OTFM_BOOL_XOR && (drive.bool_in_a != drive.bool_in_b))
		|=> logic_out_a_sink)
		else $error("logic output not following exclusive or");

	monitor_freq_a: assert property (@(posedge core_clk) disable iff (rst)
		(!rst && s_q.analog_monitor_select == `OTFM_AM_FREQ) |=>
		analog_monitor_out == $past(drive.speed_pu))
		else $error("monitor not showing speed");

	monitor_bad_a: assert property (@(posedge core_clk) disable iff (rst)
		(!rst && s_q.analog_monitor_select > `OTFM_AM_CURRENT) |=> analog_monitor_out == 16'h0000)
		else $error("monitor not zero for unsupported select");

	rdata_idle_a: assert property (@(posedge core_clk) disable iff (rst)
		(!rst && !reg_rd) |=> reg_rdata == 8'h00)
		else $error("read data not zero outside read cycle");

	pol_write_a: assert property (@(posedge core_clk) disable iff (rst)
		(!rst && reg_wr && reg_addr == `OTFM_OFS_A_POL) |=> s_q.polarity[0] == $past(reg_wdata))
		else $error("polarity write lost");

	relay_follow_a: assert property (@(posedge core_clk) disable iff (rst)
		(!rst && s_q.polarity[2] == `OTFM_POL_NO) |=> alarm_relay_energize == $past(cond[2]))
		else $error("normally open relay not following condition");

	bad_relay_a: assert property (@(posedge core_clk) disable iff (rst)
		(s_q.func_sel[2] > `OTFM_FN_LOGIC) |-> !cond[2])
		else $error("unsupported relay code gave active condition");

	reset_pol_a: assert property (@(posedge core_clk)
		rst |=> (s_q.polarity[0] == `OTFM_POL_NO && s_q.polarity[1] == `OTFM_POL_NO &&
		s_q.polarity[2] == `OTFM_POL_NC))
		else $error("polarity defaults wrong after reset");

	alarm_clear_a: assert property (@(posedge core_clk) disable iff (rst)
		(!rst && drive.alarm_clear && !drive.alarm_event) |=> !s_q.alarm_flag)
		else $error("alarm not cleared");

	stage_high_a: assert property (@(posedge core_clk) disable iff (rst)
		(!rst && drive.process_value > drive.feedback_high_limit &&
		!(drive.run_mode && drive.process_value < drive.feedback_low_limit)) |=>
		!s_q.second_stage_flag)
		else $error("second stage not off above high limit");

endmodule

// file: sim/otfm_load_model.sv
`timescale 1ns/10ps
module otfm_load_model (
	// Transistor and coil drive
	input wire logic sink_a,
	input wire logic sink_b,
	input wire logic coil_on,
	// Levels on the field wiring
	output logic pin_a,
	output logic pin_b,
	output logic contact_closed
);
	// ----------------------------------------
	// Pull-ups hold a pin high unless it sinks
	// ----------------------------------------
	assign pin_a = ~sink_a;
	assign pin_b = ~sink_b;
	assign contact_closed = coil_on;
endmodule

// file: sim/testbench.sv
`timescale 1ns/10ps
`include "otfm_regs.svh"
module testbench;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	otfm_pkg::otfm_drive_t drv;
	logic sink_a;
	logic sink_b;
	logic relay_on;
	logic [15:0] am_out;
	logic pin_a;
	logic pin_b;
	logic contact;
	int mismatches = 0;
	int tests_run = 0;
	int n;
	logic [7:0] rv;
	logic [15:0] row;
	logic e;
	// Row: function, stimulus, {pol, cond}
	logic [15:0] rows [20] = '{16'h0000, 16'h0013, 16'h0121, 16'h0132, 16'h0140,
		16'h0102, 16'h0231, 16'h02b3, 16'h0240, 16'h0353, 16'h0360, 16'h0473,
		16'h0400, 16'h0683, 16'h0691, 16'h0602, 16'h09a1, 16'h0902, 16'h0a10,
		16'hff12};
	logic [7:0] rst_vals [10] = '{8'h01, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00,
		8'h01, 8'h00, 8'h00, 8'h00};

	always #2.5 core_clk = ~core_clk;

	otfm_mux #(.WD_TICK_CYCLES(4)) i_otfm_mux (.core_clk(core_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .drive(drv), .logic_out_a_sink(sink_a),
		.logic_out_b_sink(sink_b), .alarm_relay_energize(relay_on),
		.analog_monitor_out(am_out));
	otfm_load_model i_otfm_load_model (.sink_a(sink_a), .sink_b(sink_b),
		.coil_on(relay_on), .pin_a(pin_a), .pin_b(pin_b), .contact_closed(contact));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic otfm_pkg::otfm_drive_t mk(input int st);
		otfm_pkg::otfm_drive_t d;
		d = '0;
		d.voltage_analog_input = 16'h1000;
		d.voltage_loss_threshold = 16'h0800;
		d.current_analog_input = 16'h0190;
		d.freq_set = 16'h0100;
		d.overload_level = 16'h0200;
		d.pid_dev_level = 16'h0200;
		d.feedback_high_limit = 16'h8000;
		d.feedback_low_limit = 16'h1000;
		d.process_value = 16'h4000;
		d.speed_pu = 16'h1234;
		d.current_pu = 16'habcd;
		case (st)
			1: d.run_mode = 1'b1;
			2, 3, 4, 11: begin
				d.output_on = 1'b1;
				d.freq_out = (st == 4) ? 16'h00ff : (st == 11) ? 16'h0101 : 16'h0100;
				d.ramping = (st == 3);
			end
			5: d.current = 16'h0201;
			6: d.current = 16'h0200;
			7: d.pid_error = 16'h0201;
			8: d.current_analog_input = 16'h018f;
			9: d.voltage_analog_input = 16'h07ff;
			10: d.bool_in_a = 1'b1;
			default: ;
		endcase
		if (st == 10) begin
			d.bool_in_b = 1'b1;
		end
		return d;
	endfunction

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic pulse(input int k);
		@(posedge core_clk);
		drv.alarm_event <= (k == 0);
		drv.alarm_clear <= (k == 1);
		drv.comm_activity <= (k == 2);
		@(posedge core_clk);
		drv.alarm_event <= 1'b0;
		drv.alarm_clear <= 1'b0;
		drv.comm_activity <= 1'b0;
	endtask

	task automatic pv_step(input logic [15:0] v, input logic x);
		@(posedge core_clk);
		drv.process_value <= v;
		cyc(3);
		chk("second_stage", sink_a, x);
	endtask

	task automatic end_of_test;
		$display("Checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		drv = mk(0);
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		cyc(2);
		chk("relay_dflt", contact, 1'b1);
		chk("pin_a_dflt", pin_a, 1'b1);
		for (int i = 0; i < 10; i++) begin
			rd(i[3:0], rv);
			chk("reset_value", rv, rst_vals[i]);
		end
		rd(4'hb, rv);
		chk("unmapped", rv, 8'h00);
		foreach (rows[i]) begin
			row = rows[i];
			wr(`OTFM_OFS_A_FUNC, row[15:8]);
			wr(`OTFM_OFS_B_FUNC, row[15:8]);
			wr(`OTFM_OFS_B_POL, {7'h00, row[1]});
			@(posedge core_clk);
			drv <= mk(row[7:4]);
			cyc(3);
			chk("out_a", sink_a, row[0]);
			chk("out_b", sink_b, row[0] ^ row[1]);
			chk("pin_b", pin_b, !(row[0] ^ row[1]));
		end
		for (int s = 0; s < 3; s++) begin
			wr(`OTFM_OFS_AM_SEL, s[7:0]);
			cyc(2);
			chk("monitor", am_out, (s == 0) ? 16'h1234 : (s == 1) ? 16'habcd : 16'h0);
		end
		pulse(0);
		cyc(4);
		chk("alarm_held", relay_on, 1'b0);
		pulse(1);
		cyc(3);
		chk("alarm_clear", relay_on, 1'b1);
		wr(`OTFM_OFS_RY_POL, 8'h00);
		cyc(2);
		chk("relay_no", relay_on, 1'b0);
		pulse(0);
		cyc(3);
		chk("relay_no_al", relay_on, 1'b1);
		wr(`OTFM_OFS_A_FUNC, 8'h07);
		@(posedge core_clk);
		drv <= mk(1);
		pv_step(16'h4000, 1'b0);
		pv_step(16'h0fff, 1'b1);
		pv_step(16'h8000, 1'b1);
		pv_step(16'h8001, 1'b0);
		pv_step(16'h0fff, 1'b1);
		@(posedge core_clk);
		drv.run_mode <= 1'b0;
		cyc(3);
		chk("stage_stop", sink_a, 1'b0);
		wr(`OTFM_OFS_A_FUNC, 8'h08);
		cyc(30);
		chk("wd_off", sink_a, 1'b0);
		wr(`OTFM_OFS_WD_LO, 8'h03);
		pulse(2);
		cyc(4);
		chk("wd_fed", sink_a, 1'b0);
		n = 0;
		while (sink_a !== 1'b1 && n < 40) begin
			cyc(1);
			n++;
		end
		chk("wd_timeout", sink_a, 1'b1);
		if (sink_a !== 1'b1) begin
			end_of_test();
		end
		chk("wd_early", 16'(n + 4), 16'h000d);
		pulse(2);
		cyc(2);
		chk("wd_refed", sink_a, 1'b0);
		wr(`OTFM_OFS_A_FUNC, 8'h09);
		for (int op = 0; op < 4; op++) begin
			wr(`OTFM_OFS_BOOL_OP, op[7:0]);
			for (int ab = 0; ab < 4; ab++) begin
				@(posedge core_clk);
				{drv.bool_in_a, drv.bool_in_b} <= ab[1:0];
				e = (op == 0) ? &ab[1:0] : (op == 1) ? |ab[1:0] : (op == 2) ? ^ab[1:0] : 1'b0;
				cyc(3);
				chk("bool", sink_a, e);
			end
		end
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		cyc(2);
		rd(`OTFM_OFS_RY_POL, rv);
		chk("rst_ry_pol", rv, 8'h01);
		chk("rst_relay", relay_on, 1'b1);
		rd(`OTFM_OFS_STATUS, rv);
		chk("status", rv, 8'h04);
		end_of_test();
	end
endmodule
